// [common/pir_pkg.sv]
// Constants shared by the shared-line interrupt router
package pir_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_LINES     = 8;
  localparam int NUM_LEGACY    = 16;
  localparam int NUM_ADV       = 24;
  localparam int ADV_LINE_BASE = 16;
  localparam int IRQ_W         = 4;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;
  localparam int NUM_SRC       = 5;
  localparam int NUM_PIN       = 23;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_ROUTE_LO   = 8'h04;
  localparam logic [7:0] ADDR_ROUTE_HI   = 8'h08;
  localparam logic [7:0] ADDR_PORT_IRQ   = 8'h0c;
  localparam logic [7:0] ADDR_DYN_IRQ    = 8'h10;
  localparam logic [7:0] ADDR_LINE_STATE = 8'h14;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h18;
  localparam logic [7:0] ADDR_INT_MASK   = 8'h1c;

  // ************************************************************
  // Field layout of one routing byte
  // ************************************************************
  localparam int FIELD_W    = 8;
  localparam int LINES_PER_REG = 4;
  localparam int EN_BIT     = 7;
  localparam int CTRL_ADV_BIT = 0;

  // ************************************************************
  // Legacy IRQ numbers
  // ************************************************************
  localparam int IRQ_TIMER   = 0;
  localparam int IRQ_KBD     = 1;
  localparam int IRQ_CASCADE = 2;
  localparam int IRQ_DISK    = 6;
  localparam int IRQ_RTC     = 8;
  localparam int IRQ_MOUSE   = 12;
  localparam int IRQ_FPU     = 13;
  localparam int IRQ_ATA_PRI = 14;
  localparam int IRQ_ATA_SEC = 15;

  // Selectable numbers 3-7, 9-12, 14, 15
  localparam logic [15:0] LEGAL_IRQ_MASK = 16'hdef8;
  localparam logic [15:0] IRQ_ONE        = 16'h0001;

  // ************************************************************
  // Programmable sources: serial, parallel, usb, sata, pcie
  // ************************************************************
  localparam logic [7:0] SRC_ADDR [NUM_SRC] =
    '{ADDR_PORT_IRQ, ADDR_PORT_IRQ, ADDR_DYN_IRQ, ADDR_DYN_IRQ, ADDR_DYN_IRQ};
  localparam int SRC_LANE [NUM_SRC] = '{0, 1, 0, 1, 2};
  localparam logic [3:0] SRC_IRQ_RST [NUM_SRC] = '{4'h4, 4'h7, 4'h3, 4'h3, 4'h3};
  localparam logic SRC_EN_RST [NUM_SRC] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  // Reset values
  localparam logic [3:0] ROUTE_IRQ_RST = 4'h3;
  localparam logic [NUM_PIN-1:0] PIN_RST = 23'h7fe000;

endpackage

// [rtl/pir_sync.sv]
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ns
`default_nettype none

module pir_sync
#(
  parameter int                WIDTH     = 1,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// [rtl/pir_router.sv]
// Shared-line interrupt router with APB register access
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none

// Function
// - eight shared lines, each source on one
// - mode picks legacy or advanced controller
// - legacy mode uses IRQ 0 to 15
// - advanced mode offers IRQ 0 to 23
// - IRQ 16-23 driven by lines A-H, advanced
// - legacy line steered to selectable IRQ set
// - several lines may share one IRQ
// - slot pins wired to fixed shared lines
// - sources on one line share it
// - IRQ 2 kept for cascade, never assigned
// - IRQ 0, 1, 8, 13 fixed system uses
// - serial IRQ 4, parallel IRQ 7, reprogrammable
// - USB, SATA, PCIe IRQs set at runtime
module pir_router
#(
  parameter int NUM_LINES = pir_pkg::NUM_LINES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  slot1_int_n,
  input  wire logic [3:0]  slot2_int_n,
  input  wire logic        fw_int_n,
  input  wire logic        sata_ctrl_int_n,
  input  wire logic        timer_irq,
  input  wire logic        kbd_irq,
  input  wire logic        rtc_irq,
  input  wire logic        fpu_irq,
  input  wire logic        disk_irq,
  input  wire logic        mouse_irq,
  input  wire logic        ata_pri_irq,
  input  wire logic        ata_sec_irq,
  input  wire logic        first_serial_port_irq,
  input  wire logic        first_parallel_port_irq,
  input  wire logic        usb_irq,
  input  wire logic        sata_port_irq,
  input  wire logic        pcie_irq,
  output logic      [15:0] legacy_irq,
  output logic      [23:0] adv_irq,
  output logic             adv_mode,
  output logic             irq
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (NUM_LINES != pir_pkg::NUM_LINES)
  begin : g_bad_lines
    $error("pir_router: board wiring serves exactly eight lines");
  end

  // ************************************************************
  // Pin synchronisation
  // ************************************************************
  logic [pir_pkg::NUM_PIN-1:0] pin_raw;
  logic [pir_pkg::NUM_PIN-1:0] pin_s;

  // Active-low card pins on top, active-high sources below
  assign pin_raw = {slot1_int_n, slot2_int_n, fw_int_n, sata_ctrl_int_n,
                    timer_irq, kbd_irq, rtc_irq, fpu_irq, disk_irq,
                    mouse_irq, ata_pri_irq, ata_sec_irq,
                    first_serial_port_irq, first_parallel_port_irq,
                    usb_irq, sata_port_irq, pcie_irq};

  pir_sync
  #(
    .WIDTH     (pir_pkg::NUM_PIN),
    .RESET_VAL (pir_pkg::PIN_RST)
  )
  u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  wire [3:0] slot1_n  = pin_s[22:19];
  wire [3:0] slot2_n  = pin_s[18:15];
  wire       fw_n     = pin_s[14];
  wire       sata_n   = pin_s[13];
  wire       timer_s  = pin_s[12];
  wire       kbd_s    = pin_s[11];
  wire       rtc_s    = pin_s[10];
  wire       fpu_s    = pin_s[9];
  wire       disk_s   = pin_s[8];
  wire       mouse_s  = pin_s[7];
  wire       atap_s   = pin_s[6];
  wire       atas_s   = pin_s[5];
  wire [4:0] src_s    = pin_s[4:0];

  // ************************************************************
  // Shared line wiring
  // ************************************************************
  logic [7:0] shared_line_n;
  logic [7:0] line_act;

  assign shared_line_n[0] = slot2_n[3];
  assign shared_line_n[1] = slot2_n[2] & sata_n;
  assign shared_line_n[2] = slot2_n[0] & fw_n;
  assign shared_line_n[3] = slot2_n[1];
  assign shared_line_n[4] = slot1_n[3];
  assign shared_line_n[5] = slot1_n[0];
  assign shared_line_n[6] = slot1_n[1];
  assign shared_line_n[7] = slot1_n[2];

  assign line_act = ~shared_line_n;

  // ************************************************************
  // APB slave decode
  // ************************************************************
  logic        ctrl_adv;
  logic [7:0]  int_status;
  logic [7:0]  int_mask;
  logic [7:0]  line_prev;
  logic [31:0] rd_mux;

  wire access   = psel && penable;
  wire wr_en    = access && pready && pwrite;
  wire addr_hit = (paddr == pir_pkg::ADDR_CTRL) ||
                  (paddr == pir_pkg::ADDR_ROUTE_LO) ||
                  (paddr == pir_pkg::ADDR_ROUTE_HI) ||
                  (paddr == pir_pkg::ADDR_PORT_IRQ) ||
                  (paddr == pir_pkg::ADDR_DYN_IRQ) ||
                  (paddr == pir_pkg::ADDR_LINE_STATE) ||
                  (paddr == pir_pkg::ADDR_INT_STATUS) ||
                  (paddr == pir_pkg::ADDR_INT_MASK);
  wire ctrl_wr  = wr_en && (paddr == pir_pkg::ADDR_CTRL);
  wire stat_wr  = wr_en && (paddr == pir_pkg::ADDR_INT_STATUS);
  wire mask_wr  = wr_en && (paddr == pir_pkg::ADDR_INT_MASK);

  // ************************************************************
  // Per-line routing selections
  // ************************************************************
  logic [15:0] line_vec  [NUM_LINES];
  logic [7:0]  route_rd  [NUM_LINES];

  for (genvar i = 0; i < NUM_LINES; i++)
  begin : g_line
    localparam logic [7:0] RADDR = (i < pir_pkg::LINES_PER_REG) ?
                                   pir_pkg::ADDR_ROUTE_LO : pir_pkg::ADDR_ROUTE_HI;
    localparam int LANE = (i % pir_pkg::LINES_PER_REG) * pir_pkg::FIELD_W;
    logic [3:0] sel_irq;
    logic       sel_en;
    wire  [7:0] wbyte = pwdata[LANE +: pir_pkg::FIELD_W];
    wire        legal = pir_pkg::LEGAL_IRQ_MASK[wbyte[3:0]];
    wire        hit   = wr_en && (paddr == RADDR) && legal;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        sel_irq <= pir_pkg::ROUTE_IRQ_RST;
        sel_en  <= 1'b0;
      end
      else if (hit)
      begin
        sel_irq <= wbyte[3:0];
        sel_en  <= wbyte[pir_pkg::EN_BIT];
      end
    end

    assign line_vec[i] = (sel_en && line_act[i] && !ctrl_adv) ?
                         (pir_pkg::IRQ_ONE << sel_irq) : 16'h0000;
    assign route_rd[i] = {sel_en, 3'h0, sel_irq};
  end

  // ************************************************************
  // Programmable device sources
  // ************************************************************
  logic [15:0] src_vec [pir_pkg::NUM_SRC];
  logic [7:0]  src_rd  [pir_pkg::NUM_SRC];

  for (genvar s = 0; s < pir_pkg::NUM_SRC; s++)
  begin : g_src
    localparam int LANE = pir_pkg::SRC_LANE[s] * pir_pkg::FIELD_W;
    logic [3:0] sel_irq;
    logic       sel_en;
    wire  [7:0] wbyte = pwdata[LANE +: pir_pkg::FIELD_W];
    wire        legal = pir_pkg::LEGAL_IRQ_MASK[wbyte[3:0]];
    wire        hit   = wr_en && (paddr == pir_pkg::SRC_ADDR[s]) && legal;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        sel_irq <= pir_pkg::SRC_IRQ_RST[s];
        sel_en  <= pir_pkg::SRC_EN_RST[s];
      end
      else if (hit)
      begin
        sel_irq <= wbyte[3:0];
        sel_en  <= wbyte[pir_pkg::EN_BIT];
      end
    end

    assign src_vec[s] = (sel_en && src_s[pir_pkg::NUM_SRC-1-s]) ?
                        (pir_pkg::IRQ_ONE << sel_irq) : 16'h0000;
    assign src_rd[s]  = {sel_en, 3'h0, sel_irq};
  end

  // ************************************************************
  // IRQ vector assembly
  // ************************************************************
  logic [15:0] fixed_vec;
  logic [15:0] line_or;
  logic [15:0] src_or;

  always_comb
  begin
    fixed_vec = 16'h0000;
    fixed_vec[pir_pkg::IRQ_TIMER]   = timer_s;
    fixed_vec[pir_pkg::IRQ_KBD]     = kbd_s;
    fixed_vec[pir_pkg::IRQ_CASCADE] = 1'b0;
    fixed_vec[pir_pkg::IRQ_DISK]    = disk_s;
    fixed_vec[pir_pkg::IRQ_RTC]     = rtc_s;
    fixed_vec[pir_pkg::IRQ_MOUSE]   = mouse_s;
    fixed_vec[pir_pkg::IRQ_FPU]     = fpu_s;
    fixed_vec[pir_pkg::IRQ_ATA_PRI] = atap_s;
    fixed_vec[pir_pkg::IRQ_ATA_SEC] = atas_s;
  end

  // lines may merge on one number
  always_comb
  begin
    line_or = 16'h0000;
    for (int i = 0; i < NUM_LINES; i++)
    begin
      line_or = line_or | line_vec[i];
    end
    src_or = 16'h0000;
    for (int s = 0; s < pir_pkg::NUM_SRC; s++)
    begin
      src_or = src_or | src_vec[s];
    end
  end

  wire [15:0] low_vec = fixed_vec | src_or;

  wire [15:0] next_legacy = ctrl_adv ? 16'h0000 : (low_vec | line_or);
  wire [23:0] next_adv    = ctrl_adv ? {line_act, low_vec} : 24'h000000;

  // ************************************************************
  // Control, status and mask registers
  // ************************************************************
  wire [7:0] line_rise   = line_act & ~line_prev;
  wire [7:0] stat_clr    = stat_wr ? pwdata[7:0] : 8'h00;
  // Set beats a same-cycle clear
  wire [7:0] next_status = (int_status & ~stat_clr) | line_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_adv   <= 1'b0;
      int_mask   <= 8'h00;
      int_status <= 8'h00;
      line_prev  <= 8'h00;
    end
    else
    begin
      if (ctrl_wr)
      begin
        ctrl_adv <= pwdata[pir_pkg::CTRL_ADV_BIT];
      end
      if (mask_wr)
      begin
        int_mask <= pwdata[7:0];
      end
      int_status <= next_status;
      line_prev  <= line_act;
    end
  end

  // ************************************************************
  // Read data selection
  // ************************************************************
  assign rd_mux =
    (paddr == pir_pkg::ADDR_CTRL)       ? {31'h0, ctrl_adv} :
    (paddr == pir_pkg::ADDR_ROUTE_LO)   ? {route_rd[3], route_rd[2],
                                           route_rd[1], route_rd[0]} :
    (paddr == pir_pkg::ADDR_ROUTE_HI)   ? {route_rd[7], route_rd[6],
                                           route_rd[5], route_rd[4]} :
    (paddr == pir_pkg::ADDR_PORT_IRQ)   ? {16'h0, src_rd[1], src_rd[0]} :
    (paddr == pir_pkg::ADDR_DYN_IRQ)    ? {8'h0, src_rd[4], src_rd[3], src_rd[2]} :
    (paddr == pir_pkg::ADDR_LINE_STATE) ? {24'h0, line_act} :
    (paddr == pir_pkg::ADDR_INT_STATUS) ? {24'h0, int_status} :
    (paddr == pir_pkg::ADDR_INT_MASK)   ? {24'h0, int_mask} :
                                          32'h0000_0000;

  // ************************************************************
  // APB answer: one wait cycle, registered
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access && !pready;
      prdata  <= (access && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= access && !pready && !addr_hit;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      legacy_irq <= 16'h0000;
      adv_irq    <= 24'h000000;
      adv_mode   <= 1'b0;
      irq        <= 1'b0;
    end
    else
    begin
      legacy_irq <= next_legacy;
      adv_irq    <= next_adv;
      adv_mode   <= ctrl_adv;
      irq        <= |(next_status & int_mask);
    end
  end

endmodule
`default_nettype wire

// [verif/pir_router_asserts.sv]
// Port checks for the shared-line interrupt router
`timescale 1ns/1ns
`default_nettype none
module pir_router_asserts
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  slot1_int_n,
  input wire logic [3:0]  slot2_int_n,
  input wire logic        timer_irq,
  input wire logic        rtc_irq,
  input wire logic [15:0] legacy_irq,
  input wire logic [23:0] adv_irq,
  input wire logic        adv_mode
);
  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus phases
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable;
  endsequence
  // Answer comes after one wait state
  AST_APB_WAIT: assert property (apb_setup ##1 apb_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  // Error only with the answer
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_CASCADE_IDLE: assert property (legacy_irq[2] == 1'h0)
    else $error("irq 2 driven");
  AST_LEG_OFF: assert property (adv_mode [*2] |-> legacy_irq == 16'h0)
    else $error("legacy output active in advanced mode");
  AST_ADV_OFF: assert property ((!adv_mode) [*2] |-> adv_irq == 24'h0)
    else $error("advanced output active in legacy mode");
  AST_TIMER_LEG: assert property ((timer_irq && !adv_mode) [*4] |-> legacy_irq[0])
    else $error("timer not on irq 0");
  AST_RTC_LEG: assert property ((rtc_irq && !adv_mode) [*4] |-> legacy_irq[8])
    else $error("rtc not on irq 8");
  AST_TIMER_ADV: assert property ((timer_irq && adv_mode) [*4] |-> adv_irq[0])
    else $error("timer not on advanced irq 0");
  AST_LINE_A_ADV: assert property ((!slot2_int_n[3] && adv_mode) [*4] |-> adv_irq[16])
    else $error("line a not on irq 16");
  AST_LINE_H_ADV: assert property ((!slot1_int_n[2] && adv_mode) [*4] |-> adv_irq[23])
    else $error("line h not on irq 23");
endmodule

bind pir_router pir_router_asserts u_chk
(
  .pclk        (pclk),
  .presetn     (presetn),
  .psel        (psel),
  .penable     (penable),
  .pready      (pready),
  .pslverr     (pslverr),
  .slot1_int_n (slot1_int_n),
  .slot2_int_n (slot2_int_n),
  .timer_irq   (timer_irq),
  .rtc_irq     (rtc_irq),
  .legacy_irq  (legacy_irq),
  .adv_irq     (adv_irq),
  .adv_mode    (adv_mode)
);
`default_nettype wire

// [verif/pir_card_model.sv]
// Cards and onboard devices driving the shared lines
`timescale 1ns/1ns
`default_nettype none
module pir_card_model
(
  input  wire logic [9:0] raise,
  output logic      [3:0] slot1_int_n,
  output logic      [3:0] slot2_int_n,
  output logic            fw_int_n,
  output logic            sata_ctrl_int_n
);
  // bit 0 is INTA, then B, C, D
  assign slot1_int_n     = ~raise[3:0];
  assign slot2_int_n     = ~raise[7:4];
  assign fw_int_n        = ~raise[8];
  assign sata_ctrl_int_n = ~raise[9];
endmodule
`default_nettype wire

// [verif/test_pir_router.sv]
// Self-checking bench for the shared-line interrupt router
`timescale 1ns/1ns
`default_nettype none
module test_pir_router;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq, adv_mode, fw_n, sc_n, err;
  logic [7:0]  paddr, fx;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  raise;
  logic [4:0]  pv;
  logic [3:0]  s1_n, s2_n;
  logic [15:0] legacy_irq;
  logic [23:0] adv_irq;
  int          error_cnt, tests_run;
  // Pin to line, line to IRQ, fixed and port numbers
  localparam int LINE_OF [10] = '{5, 6, 7, 4, 2, 3, 1, 0, 2, 1};
  localparam int LIRQ [8]     = '{9, 9, 10, 11, 5, 3, 14, 15};
  localparam int FIX_NUM [8]  = '{0, 1, 6, 8, 12, 13, 14, 15};
  localparam int PV_NUM [5]   = '{3, 7, 10, 11, 12};

  // Clock
  initial
  begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end

  pir_card_model u_cards
  (
    .raise(raise), .slot1_int_n(s1_n), .slot2_int_n(s2_n),
    .fw_int_n(fw_n), .sata_ctrl_int_n(sc_n)
  );

  pir_router dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slot1_int_n(s1_n), .slot2_int_n(s2_n),
    .fw_int_n(fw_n), .sata_ctrl_int_n(sc_n), .timer_irq(fx[0]), .kbd_irq(fx[1]),
    .disk_irq(fx[2]), .rtc_irq(fx[3]), .mouse_irq(fx[4]), .fpu_irq(fx[5]),
    .ata_pri_irq(fx[6]), .ata_sec_irq(fx[7]), .first_serial_port_irq(pv[0]),
    .first_parallel_port_irq(pv[1]), .usb_irq(pv[2]), .sata_port_irq(pv[3]),
    .pcie_irq(pv[4]), .legacy_irq(legacy_irq), .adv_irq(adv_irq),
    .adv_mode(adv_mode), .irq(irq)
  );

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One bus transfer, bounded wait for the answer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1)
    begin
      error_cnt++;
      tally_and_finish();
    end
    rd = prdata; err = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask

  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask

  task automatic t_reset;
    apb(1'h0, pir_pkg::ADDR_ROUTE_LO, 32'h0); chk("route_lo", 32'h03030303, rd);
    apb(1'h0, pir_pkg::ADDR_ROUTE_HI, 32'h0); chk("route_hi", 32'h03030303, rd);
    apb(1'h0, pir_pkg::ADDR_PORT_IRQ, 32'h0); chk("port_irq", 32'h00008784, rd);
    apb(1'h0, pir_pkg::ADDR_DYN_IRQ, 32'h0); chk("dyn_irq", 32'h00030303, rd);
    apb(1'h0, pir_pkg::ADDR_CTRL, 32'h0); chk("ctrl", 32'h0, rd);
    $display("reset test done");
  endtask

  task automatic t_fixed;
    for (int i = 0; i < 8; i++)
    begin
      fx <= 8'h01 << i;
      settle();
      chk("legacy_fixed", 32'h1 << FIX_NUM[i], {16'h0, legacy_irq});
    end
    fx <= 8'h00;
    $display("fixed test done");
  endtask

  task automatic t_route;
    apb(1'h1, pir_pkg::ADDR_ROUTE_LO, 32'h8b8a8989);
    apb(1'h1, pir_pkg::ADDR_ROUTE_HI, 32'h8f8e8385);
    apb(1'h1, pir_pkg::ADDR_ROUTE_HI, 32'h8f8e8382);
    apb(1'h0, pir_pkg::ADDR_ROUTE_HI, 32'h0); chk("route_hi", 32'h8f8e8385, rd);
    for (int i = 0; i < 10; i++)
    begin
      raise <= 10'h1 << i;
      settle();
      chk("legacy_line", 32'h1 << LIRQ[LINE_OF[i]], {16'h0, legacy_irq});
    end
    raise <= 10'h0c0;
    settle();
    chk("legacy_shared", 32'h200, {16'h0, legacy_irq});
    raise <= 10'h0;
    settle();
    $display("route test done");
  endtask

  task automatic t_ports;
    apb(1'h1, pir_pkg::ADDR_PORT_IRQ, 32'h00008783);
    apb(1'h1, pir_pkg::ADDR_DYN_IRQ, 32'h008c8b8a);
    for (int i = 0; i < 5; i++)
    begin
      pv <= 5'h01 << i;
      settle();
      chk("legacy_port", 32'h1 << PV_NUM[i], {16'h0, legacy_irq});
    end
    pv <= 5'h00;
    $display("port test done");
  endtask

  task automatic t_adv;
    apb(1'h1, pir_pkg::ADDR_CTRL, 32'h1);
    for (int i = 0; i < 10; i++)
    begin
      raise <= 10'h1 << i;
      settle();
      chk("adv_line", 32'h1 << (16 + LINE_OF[i]), {8'h0, adv_irq});
    end
    raise <= 10'h0;
    fx <= 8'h01;
    settle();
    chk("adv_fixed", 32'h1, {8'h0, adv_irq});
    chk("legacy_off", 32'h0, {16'h0, legacy_irq});
    chk("adv_mode_on", 32'h1, {31'h0, adv_mode});
    fx <= 8'h00;
    apb(1'h1, pir_pkg::ADDR_CTRL, 32'h0);
    settle();
    chk("adv_mode_off", 32'h0, {31'h0, adv_mode});
    $display("advanced test done");
  endtask

  task automatic t_intr;
    apb(1'h1, pir_pkg::ADDR_INT_STATUS, 32'hff);
    apb(1'h1, pir_pkg::ADDR_INT_MASK, 32'h1);
    raise <= 10'h040;
    settle();
    chk("irq_masked", 32'h0, {31'h0, irq});
    raise <= 10'h0c0;
    settle();
    apb(1'h0, pir_pkg::ADDR_LINE_STATE, 32'h0); chk("line_state", 32'h3, rd);
    raise <= 10'h0;
    settle();
    chk("irq_sticky", 32'h1, {31'h0, irq});
    apb(1'h1, pir_pkg::ADDR_INT_STATUS, 32'h1);
    settle();
    chk("irq_clear", 32'h0, {31'h0, irq});
    apb(1'h0, pir_pkg::ADDR_INT_STATUS, 32'h0); chk("status", 32'h2, rd);
    apb(1'h0, 8'h20, 32'h0); chk("slverr", 32'h1, {31'h0, err});
    chk("bad_rd", 32'h0, rd);
    $display("interrupt test done");
  endtask

  // Main sequence
  initial
  begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 8'h0; pwdata = 32'h0; fx = 8'h0; raise = 10'h0; pv = 5'h0;
    error_cnt = 0; tests_run = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_fixed();
    t_route();
    t_ports();
    t_adv();
    t_intr();
    tally_and_finish();
  end
endmodule
`default_nettype wire
